// file: dv/pbbm_properties.sv
`timescale 1ns/1ps
module pbbm_properties
    import pbbm_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // Port B link
    input wire logic [35:0] busLevel,
    input wire logic        hostOe,
    input wire logic        devOe,
    input wire logic        bSelectN,
    input wire logic        bEnable,
    input wire logic        bWrite,
    input wire logic        portBWidthSelHi,
    input wire logic        portBWidthSelLo,
    input wire logic        swapCodeHi,
    input wire logic        swapCodeLo,
    input wire logic        bigEndianSelect,
    input wire logic        oddParitySelect,
    input wire logic        portBEmptyFlag,
    input wire logic        portBParityErrorFlag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    logic [1:0] partCnt_q;
    logic       pFail;
    wire  [1:0] size   = {portBWidthSelHi, portBWidthSelLo};
    wire  [1:0] lastK  = (size == SIZE_WORD) ? 2'h1 : (size == SIZE_BYTE) ? 2'h3 : 2'h0;
    wire  [3:0] mask   = (size == SIZE_WORD) ? (bigEndianSelect ? 4'hC : 4'h3) :
                         (size == SIZE_BYTE) ? (bigEndianSelect ? 4'h8 : 4'h1) : 4'hF;
    // Reads only count while data is available; refused ones are skipped
    wire        taken  = !bSelectN && bEnable && (bWrite || portBEmptyFlag) && size != SIZE_MAIL;
    wire        isLast = partCnt_q == lastK;
    wire        rdLast = taken && !bWrite && isLast;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) partCnt_q <= 2'h0;
        else if (taken) partCnt_q <= isLast ? 2'h0 : partCnt_q + 2'h1;
        else if (bSelectN) partCnt_q <= 2'h0;
    end

    always_comb begin
        pFail = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pFail = pFail | (mask[i] & (^busLevel[i*9 +: 9] ^ oddParitySelect));
        end
    end

    sequence s_wordWrite;
        $fell(bSelectN) && bWrite && size == SIZE_WORD;
    endsequence
    sequence s_byteWrite;
        $fell(bSelectN) && bWrite && size == SIZE_BYTE;
    endsequence

    property p_word_burst;
        s_wordWrite |-> (!bSelectN && bEnable) [*2] ##1 bSelectN;
    endproperty
    property p_byte_burst;
        s_byteWrite |-> (!bSelectN && bEnable) [*4] ##1 bSelectN;
    endproperty
    property p_flag_drop;
        rdLast |=> !portBEmptyFlag;
    endproperty
    property p_flag_fall;
        $fell(portBEmptyFlag) |-> $past(rdLast);
    endproperty
    property p_parity;
        portBParityErrorFlag == !pFail;
    endproperty
    property p_dev_oe;
        devOe == (!bSelectN && !bWrite);
    endproperty
    property p_no_clash;
        !(devOe && hostOe);
    endproperty
    property p_ctrl_stable;
        taken && !isLast |=> $stable({size, swapCodeHi, swapCodeLo, bigEndianSelect});
    endproperty

    a_word_burst: assert property (p_word_burst) else $error("word write not two parts");
    a_byte_burst: assert property (p_byte_burst) else $error("byte write not four parts");
    a_flag_drop: assert property (p_flag_drop) else $error("empty flag kept after last");
    a_flag_fall: assert property (p_flag_fall) else $error("empty flag fell early");
    a_parity: assert property (p_parity) else $error("parity flag wrong");
    a_dev_oe: assert property (p_dev_oe) else $error("device drive wrong");
    a_no_clash: assert property (p_no_clash) else $error("both ends drive");
    a_ctrl_stable: assert property (p_ctrl_stable) else $error("mode changed mid word");
endmodule

// file: dv/port_b_bus_match_byte_swap_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module port_b_bus_match_byte_swap_tb;
    import pbbm_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, irq;
    logic [7:0]  wbAdr = 8'h00;
    logic [31:0] wbDatI = 32'h0, wbDatO;
    logic [35:0] a2bWord = 36'h0, a2bMailbox = 36'h0, b2aWord, b2aMailbox, v;
    logic        a2bValid = 1'b0, a2bQueueFull = 1'b0, b2aQueueEmpty = 1'b1;
    logic        a2bPop, b2aPush, aEmpty, aFull, ef, ff, mbw;
    logic [31:0] r;
    logic [1:0]  curSize = 2'h0;
    logic        curBe = 1'b0;
    logic [35:0] parts[$], pushed[$];
    int          n_mismatch = 0, checks_done = 0;

    pbbm_port_if bLink ();
    pbbm_device u_pbbm_device (.sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .portB(bLink),
        .a2bWord(a2bWord), .a2bValid(a2bValid), .a2bPop(a2bPop), .a2bQueueFull(a2bQueueFull),
        .b2aWord_q(b2aWord), .b2aPush_q(b2aPush), .b2aQueueEmpty(b2aQueueEmpty),
        .a2bMailbox(a2bMailbox), .b2aMailbox_q(b2aMailbox), .b2aMailboxWrite_q(mbw),
        .portAEmptyFlag_q(aEmpty), .portAFullFlag_q(aFull));
    pbbm_host u_pbbm_host (.sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
        .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .irq(irq), .portB(bLink));
    pbbm_properties u_pbbm_properties (.sys_clk(sys_clk), .rst_b(rst_b),
        .busLevel(bLink.busLevel), .hostOe(bLink.hostOe), .devOe(bLink.devOe),
        .bSelectN(bLink.bSelectN), .bEnable(bLink.bEnable), .bWrite(bLink.bWrite),
        .portBWidthSelHi(bLink.portBWidthSelHi), .portBWidthSelLo(bLink.portBWidthSelLo),
        .swapCodeHi(bLink.swapCodeHi), .swapCodeLo(bLink.swapCodeLo),
        .bigEndianSelect(bLink.bigEndianSelect), .oddParitySelect(bLink.oddParitySelect),
        .portBEmptyFlag(bLink.portBEmptyFlag), .portBParityErrorFlag(bLink.portBParityErrorFlag));

    initial forever #12.5 sys_clk = ~sys_clk;

    function automatic logic [35:0] swapW(input logic [35:0] w, input logic [1:0] c);
        logic [8:0] a, b, cc, d;
        {a, b, cc, d} = w;
        case (c)
            2'h0: return w;
            2'h1: return {d, cc, b, a};
            2'h2: return {cc, d, a, b};
            default: return {b, a, d, cc};
        endcase
    endfunction

    // Active lanes of transfer k, right aligned
    function automatic logic [35:0] partExp(input logic [35:0] t, input logic [1:0] s,
                                            input logic be, input int k);
        if (s == SIZE_WORD) return {18'h0, t[(be ? 1 - k : k)*18 +: 18]};
        if (s == SIZE_BYTE) return {27'h0, t[(be ? 3 - k : k)*9 +: 9]};
        return t;
    endfunction

    function automatic logic [35:0] laneOf(input logic [35:0] bus, input logic [1:0] s,
                                           input logic be);
        if (s == SIZE_WORD) return {18'h0, be ? bus[35:18] : bus[17:0]};
        if (s == SIZE_BYTE) return {27'h0, be ? bus[35:27] : bus[8:0]};
        return bus;
    endfunction

    function automatic logic badPar(input logic [35:0] t, input logic odd);
        logic f;
        f = 1'b0;
        for (int i = 0; i < 4; i++) f = f | (odd ? ~^t[i*9 +: 9] : ^t[i*9 +: 9]);
        return f;
    endfunction

    always @(posedge sys_clk) begin
        if (!bLink.bSelectN && bLink.bEnable &&
            (bLink.bWrite || bLink.portBEmptyFlag || curSize == SIZE_MAIL))
            parts.push_back(laneOf(bLink.busLevel, curSize, curBe));
        if (b2aPush || mbw) pushed.push_back(mbw ? b2aMailbox : b2aWord);
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic wbAcc(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (wbAck !== 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
        r = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic runOp(input logic [1:0] s, input logic [1:0] c, input logic be,
                         input logic odd, input logic wr, input logic [35:0] t);
        logic [35:0] img;
        int n;
        curSize = s;
        curBe = be;
        img = (wr || s == SIZE_MAIL) ? t : swapW(t, c);
        wbAcc(1'b1, REG_CTRL, {26'h0, odd, be, c, s});
        wbAcc(1'b1, REG_CLEAR, 32'h7);
        parts.delete();
        pushed.delete();
        if (wr) begin
            wbAcc(1'b1, REG_TXLO, t[31:0]);
            wbAcc(1'b1, REG_TXHI, {28'h0, t[35:32]});
        end
        else if (s == SIZE_MAIL) a2bMailbox <= t;
        else begin
            a2bWord <= t;
            a2bValid <= 1'b1;
            @(posedge sys_clk);
            `CHK("pop", 1'b1, a2bPop)
            a2bValid <= 1'b0;
            @(posedge sys_clk);
            `CHK("flag rise", 1'b1, bLink.portBEmptyFlag)
        end
        wbAcc(1'b1, REG_CMD, wr ? 32'h1 : 32'h2);
        n = 0;
        do begin
            wbAcc(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (r[wr ? 0 : 1] !== 1'b1 && n < 50);
        if (r[wr ? 0 : 1] !== 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
        `CHK("parts", s == SIZE_WORD ? 2 : s == SIZE_BYTE ? 4 : 1, parts.size())
        for (int k = 0; k < parts.size(); k++)
            `CHK("bus part", partExp(img, s, be, k), parts[k])
        if (wr) begin
            `CHK("parity", badPar(t, odd), r[ST_PERR_BIT])
            `CHK("pushes", 1, pushed.size())
            if (s == SIZE_MAIL) `CHK("mail out", t, b2aMailbox)
            if (pushed.size() > 0)
                `CHK("queue word", s == SIZE_MAIL ? t : swapW(t, c), pushed[0])
        end
        else begin
            wbAcc(1'b0, REG_RXLO, 32'h0);
            `CHK("rx lo", img[31:0], r)
            wbAcc(1'b0, REG_RXHI, 32'h0);
            `CHK("rx hi", img[35:32], r[3:0])
            if (s != SIZE_MAIL) `CHK("flag low", 1'b0, bLink.portBEmptyFlag)
        end
    endtask

    initial begin
        void'($urandom(66));
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        wbAcc(1'b0, 8'h30, 32'h0);
        `CHK("unmapped", 32'h0, r)
        wbAcc(1'b1, REG_IRQEN, 32'h1);
        runOp(SIZE_LONG, SWAP_NONE, 1'b0, 1'b1, 1'b1, 36'hF_0F0F_0F0F);
        `CHK("irq set", 1'b1, irq)
        wbAcc(1'b1, REG_CLEAR, 32'h1);
        `CHK("irq clear", 1'b0, irq)
        runOp(SIZE_LONG, SWAP_REV, 1'b0, 1'b0, 1'b0, 36'h1_2345_6789);
        `CHK("irq masked", 1'b0, irq)
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 4; c++) begin
                for (int b = 0; b < 2; b++) begin
                    v = {4'($urandom), $urandom};
                    if (c == 3 && b == 1) v = 36'hF_FFFF_FFFF;
                    runOp(2'(s), 2'(c), 1'(b), 1'($urandom), 1'b1, v);
                    v = {4'($urandom), $urandom};
                    if (c == 0 && b == 0) v = 36'h0_0000_0000;
                    runOp(2'(s), 2'(c), 1'(b), 1'($urandom), 1'b0, v);
                end
            end
        end
        @(posedge sys_clk);
        ef = !b2aQueueEmpty;
        ff = !a2bQueueFull;
        for (int i = 0; i < 30; i++) begin
            b2aQueueEmpty <= 1'($urandom);
            a2bQueueFull <= 1'($urandom);
            @(posedge sys_clk);
            `CHK("port A empty", ef, aEmpty)
            `CHK("port A full", ff, aFull)
            ef = !b2aQueueEmpty;
            ff = !a2bQueueFull;
        end
        print_verdict();
    end
endmodule

// file: logic/pbbm_device.sv
`timescale 1ns/1ps
// How it works
// - both size selects high on write: mailbox
// - both size selects high on read: mailbox out
// - both selects low: one long word per transfer
// - long writes unswapped by four swap codes
// - long reads swapped by same four codes
// - word size: two halves, endian sets lanes
// - byte size: four bytes, endian sets lane
// - unused half on word reads undefined
// - unused lanes on byte reads undefined
// - word parity checks two lanes by endian
// - byte parity checks one lane by endian
// - empty flag low on last part read
// - empty flag high cycle after word arrives
// - port A empty high after long word completes
// - skew reference is last part write edge
// - port A full high after last part read
// - parity flag low on any valid lane failure
module pbbm_device
    import pbbm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // Port B pins
    pbbm_port_if.dev         portB,
    // A-to-B queue output side
    input  wire logic [35:0] a2bWord,
    input  wire logic        a2bValid,
    output logic             a2bPop,
    input  wire logic        a2bQueueFull,
    // B-to-A queue input side
    output logic [35:0]      b2aWord_q,
    output logic             b2aPush_q,
    input  wire logic        b2aQueueEmpty,
    // Mailboxes
    input  wire logic [35:0] a2bMailbox,
    output logic [35:0]      b2aMailbox_q,
    output logic             b2aMailboxWrite_q,
    // Port A flags
    output logic             portAEmptyFlag_q,
    output logic             portAFullFlag_q
);

    wire  [1:0]  sizeSel;
    wire  [1:0]  swapCode;
    wire         be;
    wire         mailSel;
    wire         xfer;
    wire         wrXfer;
    wire         rdXfer;
    wire  [1:0]  lastIdx;
    wire         lastRd;
    wire         lastWr;
    wire  [35:0] asmNext;
    wire  [3:0]  validLanes;

    logic [35:0] cur_q;
    logic        curValid_q;
    logic [1:0]  rdPart_q;
    logic [35:0] asm_q;
    logic [1:0]  wrPart_q;

    assign sizeSel  = {portB.portBWidthSelHi, portB.portBWidthSelLo};
    assign swapCode = {portB.swapCodeHi, portB.swapCodeLo};
    assign be       = portB.bigEndianSelect;
    assign mailSel  = (sizeSel == SIZE_MAIL);
    assign xfer     = ce && !portB.bSelectN && portB.bEnable;
    assign wrXfer   = xfer && portB.bWrite;
    assign rdXfer   = xfer && !portB.bWrite;
    assign lastIdx  = lastPart(sizeSel);
    assign lastRd   = (rdPart_q == lastIdx);
    assign lastWr   = (wrPart_q == lastIdx);

    // Read side: the held long word is already swapped; parts are cut from it
    assign portB.devOe   = !portB.bSelectN && !portB.bWrite;
    assign portB.devData = mailSel ? a2bMailbox
                                   : extractPart(cur_q, sizeSel, be, rdPart_q);
    assign portB.portBEmptyFlag = curValid_q;

    // A word is popped only into an idle holding register
    assign a2bPop = ce && !curValid_q && a2bValid;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_q      <= 36'h0;
            curValid_q <= 1'b0;
            rdPart_q   <= 2'h0;
        end else if (ce) begin
            if (rdXfer && !mailSel && curValid_q) begin
                if (lastRd) begin
                    curValid_q <= 1'b0;
                    rdPart_q   <= 2'h0;
                end else begin
                    rdPart_q   <= rdPart_q + 2'h1;
                end
            end else if (a2bPop) begin
                cur_q      <= swapLanes(a2bWord, swapCode);
                curValid_q <= 1'b1;
            end
        end
    end

    // Write side: parts gather in the swapped image, undone on completion
    assign asmNext = insertPart(asm_q, portB.busLevel, sizeSel, be, wrPart_q);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            asm_q             <= 36'h0;
            wrPart_q          <= 2'h0;
            b2aWord_q         <= 36'h0;
            b2aPush_q         <= 1'b0;
            b2aMailbox_q      <= 36'h0;
            b2aMailboxWrite_q <= 1'b0;
        end else if (ce) begin
            b2aPush_q         <= 1'b0;
            b2aMailboxWrite_q <= 1'b0;
            if (wrXfer && mailSel) begin
                b2aMailbox_q      <= portB.busLevel;
                b2aMailboxWrite_q <= 1'b1;
            end else if (wrXfer) begin
                if (lastWr) begin
                    b2aWord_q <= swapLanes(asmNext, swapCode);
                    b2aPush_q <= 1'b1;
                    wrPart_q  <= 2'h0;
                end else begin
                    asm_q    <= asmNext;
                    wrPart_q <= wrPart_q + 2'h1;
                end
            end
        end
    end

    // Port A flags follow storage one clock after it changes
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            portAEmptyFlag_q <= 1'b0;
            portAFullFlag_q  <= 1'b0;
        end else if (ce) begin
            portAEmptyFlag_q <= !b2aQueueEmpty;
            portAFullFlag_q  <= !a2bQueueFull;
        end
    end

    // Only lanes that carry data for the current size are checked
    assign validLanes = laneMask(sizeSel, be);
    assign portB.portBParityErrorFlag =
        !parityFail(portB.busLevel, portB.oddParitySelect, validLanes);

endmodule

// file: logic/pbbm_host.sv
`timescale 1ns/1ps
module pbbm_host
    import pbbm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt
    output logic             irq,
    // Port B pins
    pbbm_port_if.host        portB
);

    typedef enum logic [1:0] {HS_IDLE, HS_WRITE, HS_READ} pbbm_hstate_t;

    pbbm_hstate_t      state_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [35:0]       tx_q;
    logic [35:0]       rx_q;
    logic [1:0]        part_q;
    logic [ST_W-1:0]   status_q;
    logic [ST_W-1:0]   irqEn_q;
    logic [31:0]       rdData_q;
    logic              ack_q;

    wire  [1:0]      sizeSel;
    wire             be;
    wire             mailSel;
    wire             last;
    wire             access;
    wire             wrEn;
    wire             rdTake;
    wire             stepWr;
    wire             stepRd;
    wire  [ST_W-1:0] stSet;
    wire  [ST_W-1:0] stClr;
    logic [31:0]     rdMux;

    assign sizeSel = ctrl_q[CTRL_SIZE_LSB +: 2];
    assign be      = ctrl_q[CTRL_BE_BIT];
    assign mailSel = (sizeSel == SIZE_MAIL);
    assign last    = mailSel || (part_q == lastPart(sizeSel));
    assign access  = wb_cyc_i && wb_stb_i;
    assign wrEn    = ce && access && wb_we_i && ack_q && wb_sel_i[0];
    assign stepWr  = ce && (state_q == HS_WRITE);
    // Reads wait for data unless the mailbox is addressed
    assign rdTake  = mailSel || portB.portBEmptyFlag;
    assign stepRd  = ce && (state_q == HS_READ) && rdTake;

    // Pin drive: selects and swap settings stay steady while a word moves
    assign portB.bSelectN        = (state_q == HS_IDLE);
    assign portB.bWrite          = (state_q == HS_WRITE);
    assign portB.bEnable         = (state_q == HS_WRITE) || ((state_q == HS_READ) && rdTake);
    assign portB.hostOe          = (state_q == HS_WRITE);
    assign portB.hostData        = mailSel ? tx_q : extractPart(tx_q, sizeSel, be, part_q);
    assign portB.portBWidthSelHi = sizeSel[1];
    assign portB.portBWidthSelLo = sizeSel[0];
    assign portB.swapCodeHi      = ctrl_q[CTRL_SWAP_LSB + 1];
    assign portB.swapCodeLo      = ctrl_q[CTRL_SWAP_LSB];
    assign portB.bigEndianSelect = be;
    assign portB.oddParitySelect = ctrl_q[CTRL_ODD_BIT];

    assign stSet[ST_WDONE_BIT] = stepWr && last;
    assign stSet[ST_RDONE_BIT] = stepRd && last;
    assign stSet[ST_PERR_BIT]  = stepWr && !portB.portBParityErrorFlag;
    assign stClr = (wrEn && wb_adr_i == REG_CLEAR) ? wb_dat_i[ST_W-1:0] : '0;

    always_comb begin
        unique case (wb_adr_i)
            REG_CTRL:   rdMux = {26'h0, ctrl_q};
            REG_TXLO:   rdMux = tx_q[31:0];
            REG_TXHI:   rdMux = {28'h0, tx_q[35:32]};
            REG_RXLO:   rdMux = rx_q[31:0];
            REG_RXHI:   rdMux = {28'h0, rx_q[35:32]};
            REG_STATUS: rdMux = {29'h0, status_q};
            REG_IRQEN:  rdMux = {29'h0, irqEn_q};
            REG_FLAGS:  rdMux = {29'h0, state_q != HS_IDLE, portB.portBParityErrorFlag,
                                 portB.portBEmptyFlag};
            default:    rdMux = 32'h0;
        endcase
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;
    assign irq      = |(status_q & irqEn_q);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q    <= 1'b0;
            rdData_q <= 32'h0;
            ctrl_q   <= CTRL_RESET;
            irqEn_q  <= '0;
            status_q <= '0;
        end else if (ce) begin
            ack_q    <= access && !ack_q;
            rdData_q <= rdMux;
            // A new event outranks a clear in the same cycle
            status_q <= (status_q & ~stClr) | stSet;
            if (wrEn && wb_adr_i == REG_CTRL && state_q == HS_IDLE)
                ctrl_q <= wb_dat_i[CTRL_W-1:0];
            if (wrEn && wb_adr_i == REG_IRQEN)
                irqEn_q <= wb_dat_i[ST_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= HS_IDLE;
            part_q  <= 2'h0;
            tx_q    <= 36'h0;
            rx_q    <= 36'h0;
        end else if (ce) begin
            unique case (state_q)
                HS_IDLE: begin
                    part_q <= 2'h0;
                    if (wrEn && wb_adr_i == REG_TXLO)
                        tx_q[31:0] <= wb_dat_i;
                    if (wrEn && wb_adr_i == REG_TXHI)
                        tx_q[35:32] <= wb_dat_i[3:0];
                    if (wrEn && wb_adr_i == REG_CMD && wb_dat_i[CMD_WRITE_BIT])
                        state_q <= HS_WRITE;
                    else if (wrEn && wb_adr_i == REG_CMD && wb_dat_i[CMD_READ_BIT])
                        state_q <= HS_READ;
                end
                HS_WRITE: begin
                    part_q <= last ? 2'h0 : part_q + 2'h1;
                    if (last)
                        state_q <= HS_IDLE;
                end
                HS_READ: begin
                    if (rdTake) begin
                        rx_q   <= mailSel ? portB.busLevel
                                          : insertPart(rx_q, portB.busLevel, sizeSel, be, part_q);
                        part_q <= last ? 2'h0 : part_q + 2'h1;
                        if (last)
                            state_q <= HS_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

// file: logic/pbbm_pkg.sv
package pbbm_pkg;

    localparam int LW_W   = 36;
    localparam int HALF_W = 18;
    localparam int LANE_W = 9;

    // Port B size codes, {width_sel_hi, width_sel_lo}
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_BYTE = 2'h2;
    localparam logic [1:0] SIZE_MAIL = 2'h3;

    // Swap codes, {swap_code_hi, swap_code_lo}
    localparam logic [1:0] SWAP_NONE  = 2'h0;
    localparam logic [1:0] SWAP_REV   = 2'h1;
    localparam logic [1:0] SWAP_HALF  = 2'h2;
    localparam logic [1:0] SWAP_INNER = 2'h3;

    // Controller register map (byte addresses)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CMD    = 8'h04;
    localparam logic [7:0] REG_TXLO   = 8'h08;
    localparam logic [7:0] REG_TXHI   = 8'h0C;
    localparam logic [7:0] REG_RXLO   = 8'h10;
    localparam logic [7:0] REG_RXHI   = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_CLEAR  = 8'h1C;
    localparam logic [7:0] REG_IRQEN  = 8'h20;
    localparam logic [7:0] REG_FLAGS  = 8'h24;

    // CTRL fields
    localparam int CTRL_SIZE_LSB = 0;
    localparam int CTRL_SWAP_LSB = 2;
    localparam int CTRL_BE_BIT   = 4;
    localparam int CTRL_ODD_BIT  = 5;
    localparam int CTRL_W        = 6;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // CMD, STATUS and FLAGS fields
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_READ_BIT  = 1;
    localparam int ST_WDONE_BIT  = 0;
    localparam int ST_RDONE_BIT  = 1;
    localparam int ST_PERR_BIT   = 2;
    localparam int ST_W          = 3;
    localparam int FL_EMPTY_BIT  = 0;
    localparam int FL_PERR_BIT   = 1;
    localparam int FL_BUSY_BIT   = 2;

    function automatic logic [35:0] swapLanes(input logic [35:0] w, input logic [1:0] code);
        unique case (code)
            SWAP_NONE: swapLanes = w;
            SWAP_REV:  swapLanes = {w[8:0], w[17:9], w[26:18], w[35:27]};
            SWAP_HALF: swapLanes = {w[17:0], w[35:18]};
            default:   swapLanes = {w[26:18], w[35:27], w[8:0], w[17:9]};
        endcase
    endfunction

    function automatic logic [1:0] lastPart(input logic [1:0] size);
        lastPart = (size == SIZE_WORD) ? 2'h1 : (size == SIZE_BYTE) ? 2'h3 : 2'h0;
    endfunction

    // Slot of long word taken by transfer k: half index or byte lane index
    function automatic logic [1:0] partSlot(input logic [1:0] size, input logic be,
                                            input logic [1:0] k);
        if (size == SIZE_WORD)
            partSlot = {1'b0, be ? ~k[0] : k[0]};
        else
            partSlot = be ? 2'h3 - k : k;
    endfunction

    // Bus image of transfer k; unused lanes repeat the active one
    function automatic logic [35:0] extractPart(input logic [35:0] w, input logic [1:0] size,
                                                input logic be, input logic [1:0] k);
        logic [1:0] s;
        s = partSlot(size, be, k);
        if (size == SIZE_WORD)
            extractPart = {2{w[s[0]*HALF_W +: HALF_W]}};
        else if (size == SIZE_BYTE)
            extractPart = {4{w[s*LANE_W +: LANE_W]}};
        else
            extractPart = w;
    endfunction

    function automatic logic [35:0] insertPart(input logic [35:0] w, input logic [35:0] bus,
                                               input logic [1:0] size, input logic be,
                                               input logic [1:0] k);
        logic [1:0]  s;
        logic [35:0] r;
        s = partSlot(size, be, k);
        r = w;
        if (size == SIZE_WORD)
            r[s[0]*HALF_W +: HALF_W] = be ? bus[35:18] : bus[17:0];
        else if (size == SIZE_BYTE)
            r[s*LANE_W +: LANE_W] = be ? bus[35:27] : bus[8:0];
        else
            r = bus;
        insertPart = r;
    endfunction

    function automatic logic [3:0] laneMask(input logic [1:0] size, input logic be);
        unique case (size)
            SIZE_WORD: laneMask = be ? 4'hC : 4'h3;
            SIZE_BYTE: laneMask = be ? 4'h8 : 4'h1;
            default:   laneMask = 4'hF;
        endcase
    endfunction

    function automatic logic parityFail(input logic [35:0] bus, input logic odd,
                                        input logic [3:0] mask);
        logic f;
        f = 1'b0;
        for (int i = 0; i < 4; i++)
            f = f | (mask[i] & (odd ? ~^bus[i*LANE_W +: LANE_W] : ^bus[i*LANE_W +: LANE_W]));
        parityFail = f;
    endfunction

endpackage

// file: logic/pbbm_port_if.sv
`timescale 1ns/1ps
interface pbbm_port_if;
    import pbbm_pkg::*;

    logic [35:0] hostData;
    logic        hostOe;
    logic [35:0] devData;
    logic        devOe;
    logic [35:0] busLevel;
    logic        bSelectN;
    logic        bEnable;
    logic        bWrite;
    logic        portBWidthSelHi;
    logic        portBWidthSelLo;
    logic        swapCodeHi;
    logic        swapCodeLo;
    logic        bigEndianSelect;
    logic        oddParitySelect;
    logic        portBEmptyFlag;
    logic        portBParityErrorFlag;

    // Wire level of the shared data pins; the device wins if both drive
    assign busLevel = devOe ? devData : (hostOe ? hostData : 36'h0);

    modport dev (
        input  busLevel, bSelectN, bEnable, bWrite, portBWidthSelHi, portBWidthSelLo,
               swapCodeHi, swapCodeLo, bigEndianSelect, oddParitySelect,
        output devData, devOe, portBEmptyFlag, portBParityErrorFlag
    );

    modport host (
        input  busLevel, portBEmptyFlag, portBParityErrorFlag,
        output hostData, hostOe, bSelectN, bEnable, bWrite, portBWidthSelHi,
               portBWidthSelLo, swapCodeHi, swapCodeLo, bigEndianSelect, oddParitySelect
    );
endinterface
